//--- hw/low_power_mode_clock_gating.sv
/*
 Low power mode and clock gating controller: stabilization wait before
 the CPU clock, five low power modes, per-module stop, APB registers
 and an interrupt. Assumes the CPU pulses i_standby_req, wake sources
 pulse i_wakeup, and all inputs are synchronous to i_clk.
*/
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "lpm_regs.svh"

// Summary of operation
// - Programmable wait withholds CPU clock after start.
// - Stabilization wait repeats on low power exit.
// - Stable flag reported, software polls it.
// - Sleep halts CPU; exit may switch source.
// - Deep sleep also gates DMA, transfer, memories.
// - Software standby stops CPU, peripherals, oscillators.
// - All-module stop keeps both oscillators running.
// - Each peripheral module stops on its own.
// - Deep software standby removes core power.
// - Real-time clock stays powered throughout.
// - Deep software standby ends only by reset.
// - Retention hold kept; clock settings are lost at reset.
module low_power_mode_clock_gating #(
   parameter int N_MOD = 8,
   parameter int WAIT_W = 16
) (
   // Clock, reset, enable.
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   // APB slave.
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Core and oscillator events.
   input wire logic i_standby_req,
   input wire logic i_wakeup,
   input wire logic i_osc_tick,
   // Gating outputs.
   output lpm_pkg::gate_t o_gate,
   output logic [N_MOD-1:0] o_periph_en,
   output logic [1:0] o_clk_src,
   output logic o_osc_stable,
   output logic o_rtc_pwr_en,
   output logic o_irq
);

   localparam int IW = `LPM_IRQ_W;

   typedef struct packed {
      lpm_pkg::st_t st;
      logic start;
      logic [2:0] mode;
      logic auto_sw;
      logic [1:0] auto_src;
      logic [1:0] clk_src;
      logic [2:0] cur_mode;
      logic [WAIT_W-1:0] wait_cfg;
      logic [N_MOD-1:0] mstop;
      logic [IW-1:0] istat;
      logic [IW-1:0] imask;
      lpm_pkg::gate_t gate;
      logic [N_MOD-1:0] periph;
      logic stable;
      logic rtc;
      logic irq;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } state_t;

   // Reset parks in the wait state: the oscillator has just started.
   localparam state_t RST_S = '{
      st: lpm_pkg::ST_WAIT,
      start: 1'h1,
      mode: `LPM_MODE_RST,
      auto_sw: 1'h0,
      auto_src: `LPM_SRC_RST,
      clk_src: `LPM_SRC_RST,
      cur_mode: `LPM_MODE_RST,
      wait_cfg: WAIT_W'(`LPM_WAIT_RST),
      mstop: '1,
      istat: '0,
      imask: '0,
      gate: lpm_pkg::gate_for(lpm_pkg::ST_WAIT),
      periph: '0,
      stable: 1'h0,
      rtc: 1'h1,
      irq: 1'h0,
      prdata: 32'h0,
      pready: 1'h0,
      pslverr: 1'h0
   };

   state_t q;
   state_t d;
   logic cnt_done;
   logic cnt_stop;
   logic acc;
   logic wr;
   logic [IW-1:0] ev;
   logic [IW-1:0] clr;
   logic lpm_st;

   assign lpm_st = q.st inside {lpm_pkg::ST_SLEEP, lpm_pkg::ST_DSLEEP,
                                lpm_pkg::ST_ALLSTOP, lpm_pkg::ST_SWSTBY};
   assign cnt_stop = q.st inside {lpm_pkg::ST_SWSTBY, lpm_pkg::ST_DSW};

   stab_wait_counter #(
      .WAIT_W(WAIT_W)
   ) stab_wait_counter_inst (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_ce(i_ce),
      .i_start(q.start),
      .i_stop(cnt_stop),
      .i_tick(i_osc_tick),
      .i_wait(q.wait_cfg),
      .o_done(cnt_done)
   );

   always_comb begin
      d = q;
      d.start = 1'h0;
      ev = '0;
      clr = '0;
      acc = i_psel && i_penable && q.pready;
      wr = acc && i_pwrite;
      // Register writes take effect at the edge that completes the access.
      if (wr) begin
         unique case (i_paddr)
            `LPM_CTRL_OFS: begin
               d.mode = i_pwdata[`LPM_CTRL_MODE_LSB +: 3];
               d.auto_sw = i_pwdata[`LPM_CTRL_AUTO_BIT];
               d.auto_src = i_pwdata[`LPM_CTRL_SRC_LSB +: 2];
            end
            `LPM_WAIT_OFS: d.wait_cfg = i_pwdata[WAIT_W-1:0];
            `LPM_MSTOP_OFS: d.mstop = i_pwdata[N_MOD-1:0];
            `LPM_ISTAT_OFS: clr = i_pwdata[IW-1:0];
            `LPM_IMASK_OFS: d.imask = i_pwdata[IW-1:0];
            `LPM_CLKSRC_OFS: d.clk_src = i_pwdata[1:0];
            default: ;
         endcase
      end
      unique case (q.st)
         lpm_pkg::ST_WAIT: begin
            // The start pulse guards against a stale expiry flag.
            if (cnt_done && !q.start) begin
               d.st = lpm_pkg::ST_RUN;
               ev[`LPM_IRQ_STAB] = 1'h1;
            end
         end
         lpm_pkg::ST_RUN: begin
            if (i_standby_req) begin
               d.cur_mode = q.mode;
               ev[`LPM_IRQ_ENTRY] = 1'h1;
               unique case (q.mode)
                  `LPM_MODE_SLEEP: d.st = lpm_pkg::ST_SLEEP;
                  `LPM_MODE_DSLEEP: d.st = lpm_pkg::ST_DSLEEP;
                  `LPM_MODE_ALLSTOP: begin
                     // Refused unless software has stopped every module.
                     if (&q.mstop) begin
                        d.st = lpm_pkg::ST_ALLSTOP;
                     end else begin
                        d.cur_mode = q.cur_mode;
                        ev[`LPM_IRQ_ENTRY] = 1'h0;
                        ev[`LPM_IRQ_REFUSE] = 1'h1;
                     end
                  end
                  `LPM_MODE_SWSTBY: d.st = lpm_pkg::ST_SWSTBY;
                  `LPM_MODE_DSW: d.st = lpm_pkg::ST_DSW;
                  default: begin
                     d.cur_mode = q.cur_mode;
                     ev[`LPM_IRQ_ENTRY] = 1'h0;
                     ev[`LPM_IRQ_REFUSE] = 1'h1;
                  end
               endcase
            end
         end
         lpm_pkg::ST_SLEEP,
         lpm_pkg::ST_DSLEEP,
         lpm_pkg::ST_ALLSTOP,
         lpm_pkg::ST_SWSTBY: begin
            if (i_wakeup) begin
               d.st = lpm_pkg::ST_WAIT;
               d.start = 1'h1;
               ev[`LPM_IRQ_WAKE] = 1'h1;
               if (q.st == lpm_pkg::ST_SLEEP && q.auto_sw) begin
                  d.clk_src = q.auto_src;
               end
            end
         end
         lpm_pkg::ST_DSW: begin
            // No wake path: only the device reset leaves this state.
            d.st = lpm_pkg::ST_DSW;
         end
      endcase
      d.gate = lpm_pkg::gate_for(d.st);
      if (d.st inside {lpm_pkg::ST_ALLSTOP, lpm_pkg::ST_SWSTBY, lpm_pkg::ST_DSW}) begin
         d.periph = '0;
      end else begin
         d.periph = ~d.mstop;
      end
      d.stable = cnt_done;
      d.rtc = 1'h1;
      // A new event wins over a write-one-to-clear in the same cycle.
      d.istat = (q.istat & ~clr) | ev;
      d.irq = |(d.istat & d.imask);
      d.pready = i_psel && i_penable && !q.pready;
      d.pslverr = 1'h0;
      d.prdata = 32'h0;
      if (d.pready) begin
         unique case (i_paddr)
            `LPM_CTRL_OFS: begin
               d.prdata[`LPM_CTRL_MODE_LSB +: 3] = q.mode;
               d.prdata[`LPM_CTRL_AUTO_BIT] = q.auto_sw;
               d.prdata[`LPM_CTRL_SRC_LSB +: 2] = q.auto_src;
            end
            `LPM_WAIT_OFS: d.prdata[WAIT_W-1:0] = q.wait_cfg;
            `LPM_MSTOP_OFS: d.prdata[N_MOD-1:0] = q.mstop;
            `LPM_STATUS_OFS: begin
               d.prdata[`LPM_ST_STABLE_BIT] = q.stable;
               d.prdata[`LPM_ST_CPU_BIT] = q.gate.cpu;
               d.prdata[`LPM_ST_SRC_LSB +: 2] = q.clk_src;
               d.prdata[`LPM_ST_MODE_LSB +: 3] = q.cur_mode;
            end
            `LPM_ISTAT_OFS: d.prdata[IW-1:0] = q.istat;
            `LPM_IMASK_OFS: d.prdata[IW-1:0] = q.imask;
            `LPM_CLKSRC_OFS: d.prdata[1:0] = q.clk_src;
            default: d.pslverr = 1'h1;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q <= RST_S;
      end else if (i_ce) begin
         q <= d;
      end
   end

   assign o_prdata = q.prdata;
   assign o_pready = q.pready;
   assign o_pslverr = q.pslverr;
   assign o_gate = q.gate;
   assign o_periph_en = q.periph;
   assign o_clk_src = q.clk_src;
   assign o_osc_stable = q.stable;
   assign o_rtc_pwr_en = q.rtc;
   assign o_irq = q.irq;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   stab_gate_a: assert property (o_gate.cpu |-> o_osc_stable)
      else $error("CPU clock on without a stable oscillator.");

   rewait_exit_a: assert property (i_ce && lpm_st && i_wakeup
      |=> q.st == lpm_pkg::ST_WAIT && q.start && !o_gate.cpu)
      else $error("Low power exit skipped the stabilization wait.");

   stable_flag_a: assert property ((i_ce && cnt_done) |=> o_osc_stable)
      else $error("Stable flag does not follow the counter.");

   sleep_gate_a: assert property (q.st == lpm_pkg::ST_SLEEP
      |-> !o_gate.cpu && o_gate.ram && o_gate.dma && o_gate.main_osc)
      else $error("Sleep gating wrong.");

   auto_src_a: assert property (i_ce && q.st == lpm_pkg::ST_SLEEP
      && i_wakeup && q.auto_sw |=> o_clk_src == $past(q.auto_src))
      else $error("Clock source not switched on sleep exit.");

   dsleep_gate_a: assert property (q.st == lpm_pkg::ST_DSLEEP
      |-> !o_gate.cpu && !o_gate.dma && !o_gate.data_transfer_controller && !o_gate.rom
      && !o_gate.ram && o_periph_en == ~q.mstop)
      else $error("Deep sleep gating wrong.");

   swstby_gate_a: assert property (q.st == lpm_pkg::ST_SWSTBY
      |-> !o_gate.cpu && o_periph_en == '0 && !o_gate.main_osc && !o_gate.osc)
      else $error("Software standby gating wrong.");

   allstop_gate_a: assert property (q.st == lpm_pkg::ST_ALLSTOP
      |-> !o_gate.cpu && o_periph_en == '0 && o_gate.main_osc)
      else $error("All-module stop gating wrong.");

   mstop_run_a: assert property (q.st == lpm_pkg::ST_RUN
      |-> o_periph_en == ~q.mstop)
      else $error("Module stop bits not honoured.");

   dsw_power_a: assert property (q.st == lpm_pkg::ST_DSW
      |-> !o_gate.pwr && !o_gate.main_osc && o_periph_en == '0)
      else $error("Deep standby leaves power on.");

   rtc_power_a: assert property (o_rtc_pwr_en)
      else $error("Real-time clock power dropped.");

   dsw_stuck_a: assert property (q.st == lpm_pkg::ST_DSW
      |=> q.st == lpm_pkg::ST_DSW [*2])
      else $error("Deep standby left without reset.");

   dsw_retain_a: assert property (q.st == lpm_pkg::ST_DSW |-> o_gate.retain)
      else $error("Retention hold missing in deep standby.");

   cnt_release_a: assert property ($rose(o_gate.cpu)
      |-> $past(cnt_done) && !$past(q.start))
      else $error("CPU clock released before the counter expired.");

   req_entry_a: assert property (q.st == lpm_pkg::ST_RUN
      && !(i_ce && i_standby_req) |=> q.st == lpm_pkg::ST_RUN)
      else $error("Low power entry without a standby request.");

   refuse_code_a: assert property (q.st == lpm_pkg::ST_RUN && i_ce && i_standby_req
      && q.mode > `LPM_MODE_DSW |=> q.st == lpm_pkg::ST_RUN
      && q.istat[`LPM_IRQ_REFUSE] && q.cur_mode == $past(q.cur_mode))
      else $error("Undefined mode code was not refused.");

   allstop_deny_a: assert property (q.st == lpm_pkg::ST_RUN && i_ce && i_standby_req
      && q.mode == `LPM_MODE_ALLSTOP && !(&q.mstop) |=> q.st == lpm_pkg::ST_RUN)
      else $error("All-module stop entered with modules running.");

   stab_event_a: assert property ($rose(o_gate.cpu) |-> q.istat[`LPM_IRQ_STAB])
      else $error("Stabilization event not flagged.");

   swstby_count_a: assert property ((i_ce && q.st == lpm_pkg::ST_SWSTBY) |=> !cnt_done)
      else $error("Wait counter kept its expiry with oscillators stopped.");

   sleep_cv: cover property (q.st == lpm_pkg::ST_SLEEP ##1 q.st == lpm_pkg::ST_WAIT);
   dsw_cv: cover property (q.st == lpm_pkg::ST_RUN ##1 q.st == lpm_pkg::ST_DSW);
   swstby_cv: cover property (q.st == lpm_pkg::ST_SWSTBY ##1 q.st == lpm_pkg::ST_WAIT);
   release_cv: cover property ($rose(o_gate.cpu));
   refuse_cv: cover property (q.st == lpm_pkg::ST_RUN && i_standby_req && q.mode > `LPM_MODE_DSW);

endmodule

//--- hw/lpm_pkg.sv
/*
 Types shared by the low power mode controller: controller states and
 the bundle of clock, oscillator and power enables it drives out.
 Assumes the gated modules treat a low enable as clock or power off.
*/
package lpm_pkg;

   typedef enum logic [2:0] {
      ST_WAIT,
      ST_RUN,
      ST_SLEEP,
      ST_DSLEEP,
      ST_ALLSTOP,
      ST_SWSTBY,
      ST_DSW
   } st_t;

   typedef struct packed {
      logic cpu;
      logic dma;
      logic data_transfer_controller;
      logic rom;
      logic ram;
      logic main_osc;
      logic osc;
      logic pwr;
      logic retain;
   } gate_t;

   function automatic gate_t gate_for(st_t s);
      gate_t g;
      g = '{cpu: 1'h0, dma: 1'h1, data_transfer_controller: 1'h1, rom: 1'h1, ram: 1'h1,
            main_osc: 1'h1, osc: 1'h1, pwr: 1'h1, retain: 1'h0};
      if (s == ST_RUN) begin
         g.cpu = 1'h1;
      end
      if (s inside {ST_DSLEEP, ST_ALLSTOP, ST_SWSTBY, ST_DSW}) begin
         g.dma = 1'h0;
         g.data_transfer_controller = 1'h0;
         g.rom = 1'h0;
         g.ram = 1'h0;
      end
      if (s inside {ST_SWSTBY, ST_DSW}) begin
         g.main_osc = 1'h0;
         g.osc = 1'h0;
      end
      if (s == ST_DSW) begin
         g.pwr = 1'h0;
         g.retain = 1'h1;
      end
      return g;
   endfunction

endpackage

//--- hw/lpm_regs.svh
/*
 Register map, field positions, reset values and mode codes of the
 low power mode and clock gating controller. Assumes a 32-bit APB
 slave with byte addresses and one register per aligned word.
*/
`ifndef LPM_REGS_SVH
`define LPM_REGS_SVH

`define LPM_CTRL_OFS 8'h00
`define LPM_WAIT_OFS 8'h04
`define LPM_MSTOP_OFS 8'h08
`define LPM_STATUS_OFS 8'h0C
`define LPM_ISTAT_OFS 8'h10
`define LPM_IMASK_OFS 8'h14
`define LPM_CLKSRC_OFS 8'h18

`define LPM_CTRL_MODE_LSB 0
`define LPM_CTRL_AUTO_BIT 3
`define LPM_CTRL_SRC_LSB 4

`define LPM_ST_STABLE_BIT 0
`define LPM_ST_CPU_BIT 1
`define LPM_ST_SRC_LSB 2
`define LPM_ST_MODE_LSB 4

`define LPM_MODE_SLEEP 3'h0
`define LPM_MODE_DSLEEP 3'h1
`define LPM_MODE_ALLSTOP 3'h2
`define LPM_MODE_SWSTBY 3'h3
`define LPM_MODE_DSW 3'h4

`define LPM_IRQ_STAB 0
`define LPM_IRQ_ENTRY 1
`define LPM_IRQ_WAKE 2
`define LPM_IRQ_REFUSE 3
`define LPM_IRQ_W 4

`define LPM_MODE_RST 3'h0
`define LPM_SRC_RST 2'h0
`define LPM_WAIT_RST 16'h00FF

`endif

//--- hw/stab_wait_counter.sv
/*
 Oscillation stabilization wait counter. Loads the wait setting on a
 start pulse and counts oscillator ticks down to expiry. Assumes
 i_tick is one cycle per starting-oscillator cycle, synchronous to i_clk.
*/
`timescale 1ns/1ps

module stab_wait_counter #(
   parameter int WAIT_W = 16
) (
   // Clock, reset, enable.
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   // Control.
   input wire logic i_start,
   input wire logic i_stop,
   input wire logic i_tick,
   input wire logic [WAIT_W-1:0] i_wait,
   // Expiry flag.
   output logic o_done
);

   typedef struct packed {
      logic [WAIT_W-1:0] cnt;
      logic busy;
      logic done;
   } cnt_state_t;

   cnt_state_t q;
   cnt_state_t d;

   // Stop wins over start, since a stopped oscillator produces no ticks.
   always_comb begin
      d = q;
      if (i_stop) begin
         d.busy = 1'h0;
         d.done = 1'h0;
      end else if (i_start) begin
         d.cnt = i_wait;
         d.busy = 1'h1;
         d.done = 1'h0;
      end else if (q.busy && i_tick) begin
         if (q.cnt == '0) begin
            d.busy = 1'h0;
            d.done = 1'h1;
         end else begin
            d.cnt = q.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q <= '0;
      end else if (i_ce) begin
         q <= d;
      end
   end

   assign o_done = q.done;

   cnt_expire_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_ce && q.busy && i_tick && q.cnt == '0 && !i_stop && !i_start) |=> o_done)
      else $error("Wait counter did not expire at zero.");

endmodule

//--- test/lpm_partner_model.sv
/*
 Far-side model: the CPU that issues standby requests, the wake sources
 and the starting oscillator. Assumes the controller samples all three on
 the rising edge of i_clk.
*/
`timescale 1ns/1ps

module lpm_partner_model (
   // Clock and gating levels.
   input wire logic i_clk,
   input wire lpm_pkg::gate_t i_gate,
   // Events to the controller.
   output logic o_standby_req,
   output logic o_wakeup,
   output logic o_osc_tick
);
   initial begin
      o_standby_req = 1'b0;
      o_wakeup = 1'b0;
      o_osc_tick = 1'b0;
   end

   // A stopped oscillator gives no ticks, so the wait cannot start early.
   always @(posedge i_clk) begin
      o_osc_tick <= ~o_osc_tick & (i_gate.osc | i_gate.main_osc);
   end

   task automatic standby();
      @(posedge i_clk);
      o_standby_req <= 1'b1;
      @(posedge i_clk);
      o_standby_req <= 1'b0;
   endtask

   task automatic wake();
      @(posedge i_clk);
      o_wakeup <= 1'b1;
      @(posedge i_clk);
      o_wakeup <= 1'b0;
   endtask
endmodule

//--- test/tb_low_power_mode_clock_gating.sv
/*
 Self-checking bench for the low power mode controller: APB register
 tasks, mode entry and exit through the partner model, and a reset exit
 from deep software standby. Assumes one 125 MHz clock.
*/
`timescale 1ns/1ps
`include "lpm_regs.svh"

module tb_low_power_mode_clock_gating;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic [31:0] rdata;
   logic pready, pslverr, rerr, req, wake, tick, stable, rtc, irq;
   lpm_pkg::gate_t gate;
   logic [7:0] pen;
   logic [1:0] src;
   int err_total = 0;
   int checked = 0;
   int cycles = 0;
   int n;

   low_power_mode_clock_gating #(.N_MOD(8), .WAIT_W(16)) low_power_mode_clock_gating_inst (
      .i_clk(clk), .i_resetn(resetn), .i_ce(ce), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_standby_req(req), .i_wakeup(wake),
      .i_osc_tick(tick), .o_gate(gate), .o_periph_en(pen), .o_clk_src(src),
      .o_osc_stable(stable), .o_rtc_pwr_en(rtc), .o_irq(irq));

   lpm_partner_model lpm_partner_model_inst (
      .i_clk(clk), .i_gate(gate), .o_standby_req(req), .o_wakeup(wake), .o_osc_tick(tick));

   initial begin
      forever #4 clk = ~clk;
   end

   task automatic report_and_stop();
      if (err_total == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // The whole sequence needs under two thousand cycles; this ceiling cuts a hang.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rdata = prdata;
      rerr = pslverr;
      chk("pready", 1, 32'(pready));
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_cpu(output int c);
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (gate.cpu !== 1'b1 && c < 3000);
      chk("cpu_release", 1, 32'(gate.cpu));
   endtask

   // Expected enables: modes 0 to 4, 5 for normal run, 6 for the wait.
   function automatic logic [31:0] gexp(input int m);
      logic mem;
      logic osc;
      mem = !(m inside {1, 2, 3, 4});
      osc = !(m inside {3, 4});
      return {23'h0, m == 5, mem, mem, mem, mem, osc, osc, m != 4, m == 4};
   endfunction

   task automatic enter(input logic [31:0] ctrl);
      apb(`LPM_CTRL_OFS, 1'b1, ctrl);
      lpm_partner_model_inst.standby();
      repeat (3) @(posedge clk);
   endtask

   initial begin
      repeat (20) @(posedge clk);
      chk("gate_rst", gexp(6), {23'h0, gate});
      chk("rtc_rst", 1, 32'(rtc));
      resetn <= 1'b1;
      apb(`LPM_WAIT_OFS, 1'b0, 32'h0);
      chk("wait_rst", 32'h000000FF, rdata);
      apb(`LPM_MSTOP_OFS, 1'b0, 32'h0);
      chk("mstop_rst", 32'h000000FF, rdata);
      apb(8'h1C, 1'b0, 32'h0);
      chk("unmapped_err", 1, 32'(rerr));
      chk("unmapped_data", 0, rdata);
      wait_cpu(n);
      chk("stable", 1, 32'(stable));
      apb(`LPM_STATUS_OFS, 1'b0, 32'h0);
      chk("stable_poll", 1, 32'(rdata[0]));
      chk("cpu_poll", 1, 32'(rdata[1]));
      apb(`LPM_WAIT_OFS, 1'b1, 32'h00000003);
      apb(`LPM_IMASK_OFS, 1'b1, 32'h00000002);
      apb(`LPM_MSTOP_OFS, 1'b1, 32'h000000F0);
      repeat (3) @(posedge clk);
      chk("periph_run", 32'h0F, {24'h0, pen});
      ce <= 1'b0;
      lpm_partner_model_inst.standby();
      repeat (2) @(posedge clk);
      chk("ce_freeze", gexp(5), {23'h0, gate});
      ce <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         if (m != 2) begin
            enter(m);
            chk("gate_mode", gexp(m), {23'h0, gate});
            chk("periph_mode", (m == 3) ? 32'h0 : 32'h0F, {24'h0, pen});
            chk("irq_entry", 1, 32'(irq));
            apb(`LPM_ISTAT_OFS, 1'b1, 32'h0000000F);
            lpm_partner_model_inst.wake();
            repeat (2) @(posedge clk);
            chk("cpu_held", 0, 32'(gate.cpu));
            wait_cpu(n);
            chk("wait_len", 1, 32'(n >= 5));
            chk("gate_run", gexp(5), {23'h0, gate});
            chk("irq_masked", 0, 32'(irq));
         end
      end
      enter(32'h5);
      chk("mode_refused", gexp(5), {23'h0, gate});
      apb(`LPM_ISTAT_OFS, 1'b0, 32'h0);
      chk("mode_refuse_flag", 1, 32'(rdata[3]));
      apb(`LPM_STATUS_OFS, 1'b0, 32'h0);
      chk("mode_kept", 3, 32'(rdata[6:4]));
      apb(`LPM_ISTAT_OFS, 1'b1, 32'h0000000F);
      enter(32'h2);
      chk("allstop_refused", gexp(5), {23'h0, gate});
      apb(`LPM_ISTAT_OFS, 1'b0, 32'h0);
      chk("refuse_flag", 1, 32'(rdata[3]));
      apb(`LPM_MSTOP_OFS, 1'b1, 32'h000000FF);
      enter(32'h2);
      chk("allstop_gate", gexp(2), {23'h0, gate});
      chk("allstop_periph", 0, {24'h0, pen});
      lpm_partner_model_inst.wake();
      wait_cpu(n);
      enter(32'h28);
      lpm_partner_model_inst.wake();
      repeat (2) @(posedge clk);
      chk("auto_src", 2, {30'h0, src});
      wait_cpu(n);
      apb(`LPM_CLKSRC_OFS, 1'b1, 32'h00000001);
      apb(`LPM_STATUS_OFS, 1'b0, 32'h0);
      chk("src_write", 1, {30'h0, src});
      chk("src_status", 32'h00000007, rdata);
      enter(32'h4);
      chk("dsw_gate", gexp(4), {23'h0, gate});
      chk("dsw_rtc", 1, 32'(rtc));
      lpm_partner_model_inst.wake();
      repeat (20) @(posedge clk);
      chk("dsw_stays", gexp(4), {23'h0, gate});
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      chk("dsw_reset", gexp(6), {23'h0, gate});
      resetn <= 1'b1;
      apb(`LPM_CTRL_OFS, 1'b0, 32'h0);
      chk("ctrl_lost", 0, rdata);
      wait_cpu(n);
      chk("gate_after", gexp(5), {23'h0, gate});
      report_and_stop();
   end
endmodule
